// ==== rtl/tick_timer_regs.svh ====
// register offsets, field positions and reset values of the period timer
`ifndef TICK_TIMER_REGS_SVH
`define TICK_TIMER_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADDR_TICK_COUNT 4'h0
`define ADDR_TICK_CONTROL 4'h4
`define ADDR_PERIOD_LIMIT 4'h8
`define ADDR_IRQ_FLAGS 4'hc
`define ADDR_IRQ_ENABLES 4'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_PRESCALE_LO 0
`define CTRL_RUN_BIT 2
`define CTRL_POSTSCALE_LO 3
`define CTRL_WRITE_MASK 8'h7f
`define IRQ_MATCH_BIT 1

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define RST_TICK_COUNT 8'h00
`define RST_TICK_CONTROL 8'h00
`define RST_PERIOD_LIMIT 8'hff
`define INSTR_CLK_DIV 2'h3
`define PRESCALE_TERM_4 4'h3
`define PRESCALE_TERM_16 4'hf

`endif

// ==== rtl/tick_timer_pkg.sv ====
// types shared by the period timer files
package tick_timer_pkg;
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV4 = 2'b01,
    PRE_DIV16 = 2'b10
  } prescale_e;
endpackage

// ==== rtl/tick_prescaler.sv ====
// prescaler that turns instruction-clock enables into counter ticks
`timescale 1ns/1ps
`include "tick_timer_regs.svh"
module tick_prescaler
  import tick_timer_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic i_instr_en,
  input wire logic [1:0] i_prescale_select,
  // tick
  output logic o_tick
);
  logic [3:0] pre_count;
  logic [3:0] next_pre_count;
  logic [3:0] term;
  logic at_term;
  prescale_e mode;

  assign mode = i_prescale_select[1] ? PRE_DIV16 :
                (i_prescale_select[0] ? PRE_DIV4 : PRE_DIV1);
  assign term = (mode == PRE_DIV16) ? `PRESCALE_TERM_16 :
                (mode == PRE_DIV4) ? `PRESCALE_TERM_4 : 4'h0;
  assign at_term = (pre_count >= term);
  assign o_tick = i_run && i_instr_en && at_term && !i_clear;
  assign next_pre_count = at_term ? 4'h0 : pre_count + 4'h1;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_count <= 4'h0;
    end else if (i_clear) begin
      pre_count <= 4'h0;
    end else if (i_run && i_instr_en) begin
      pre_count <= next_pre_count;
    end
  end
endmodule

// ==== rtl/period_timer.sv ====
// 8-bit period timer with prescaler, postscaler and match interrupt
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "tick_timer_regs.svh"

module period_timer
  import tick_timer_pkg::*;
#(
  parameter int POST_WIDTH = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // serial port shift clock source
  output logic o_ssp_match,
  // pwm time base
  output logic [7:0] o_pwm_count,
  output logic o_pwm_match,
  // interrupt
  output logic o_irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] tick_count;
  logic [6:0] tick_control;
  logic [7:0] period_limit;
  logic match_irq_flag;
  logic match_irq_enable;
  logic [POST_WIDTH-1:0] post_count;
  logic [1:0] instr_div;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // enables sit at 0x1 so the four timer words keep word-aligned offsets
  wire sel_count = (i_addr == `ADDR_TICK_COUNT);
  wire sel_ctrl = (i_addr == `ADDR_TICK_CONTROL);
  wire sel_period = (i_addr == `ADDR_PERIOD_LIMIT);
  wire sel_flags = (i_addr == `ADDR_IRQ_FLAGS);
  wire wr_count = i_wr && sel_count;
  wire wr_ctrl = i_wr && sel_ctrl;
  wire wr_period = i_wr && sel_period;
  wire wr_flags = i_wr && sel_flags;
  wire sel_enables = (i_addr == `ADDR_IRQ_ENABLES);
  wire wr_enables = i_wr && sel_enables;

  wire run = tick_control[`CTRL_RUN_BIT];
  wire [1:0] prescale_select = tick_control[1:0];
  wire [3:0] postscale_select = tick_control[6:3];
  wire clear_scalers = wr_count || wr_ctrl;

  // instruction clock is the system clock divided by four
  wire instr_en = (instr_div == `INSTR_CLK_DIV);
  wire tick;
  wire period_hit = (tick_count == period_limit);
  wire match_pulse = tick && period_hit;
  wire post_fire = match_pulse &&
                   (post_count == POST_WIDTH'(postscale_select));
  wire [POST_WIDTH-1:0] next_post_count =
    post_fire ? '0 : post_count + POST_WIDTH'(1);
  wire [7:0] next_tick_count = period_hit ? 8'h00 : tick_count + 8'h01;

  wire [7:0] rd_value =
    sel_count ? tick_count :
    sel_ctrl ? {1'b0, tick_control} :
    sel_period ? period_limit :
    sel_flags ? {6'h00, match_irq_flag, 1'b0} :
    sel_enables ? {6'h00, match_irq_enable, 1'b0} : 8'h00;

  tick_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(clear_scalers),
    .i_run(run),
    .i_instr_en(instr_en),
    .i_prescale_select(prescale_select),
    .o_tick(tick)
  );

  // ----------------------------------------
  // instruction clock divider
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // ----------------------------------------
  // counter and period
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_count <= `RST_TICK_COUNT;
    end else if (wr_count) begin
      tick_count <= i_wdata;
    end else if (tick) begin
      tick_count <= next_tick_count;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      period_limit <= `RST_PERIOD_LIMIT;
    end else if (wr_period) begin
      period_limit <= i_wdata;
    end
  end

  // control write does not touch tick_count
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_control <= 7'(`RST_TICK_CONTROL);
    end else if (wr_ctrl) begin
      tick_control <= i_wdata[6:0];
    end
  end

  // ----------------------------------------
  // postscaler
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      post_count <= '0;
    end else if (clear_scalers) begin
      post_count <= '0;
    end else if (match_pulse) begin
      post_count <= next_post_count;
    end
  end

  // ----------------------------------------
  // interrupt flag and enable
  // ----------------------------------------
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      match_irq_flag <= 1'b0;
    end else if (post_fire) begin
      match_irq_flag <= 1'b1;
    end else if (wr_flags && i_wdata[`IRQ_MATCH_BIT]) begin
      match_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      match_irq_enable <= 1'b0;
    end else if (wr_enables) begin
      match_irq_enable <= i_wdata[`IRQ_MATCH_BIT];
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
      o_ssp_match <= 1'b0;
      o_pwm_match <= 1'b0;
      o_pwm_count <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_value : 8'h00;
      o_ssp_match <= match_pulse;
      o_pwm_match <= match_pulse;
      o_pwm_count <= tick_count;
      o_irq <= match_irq_flag && match_irq_enable;
    end
  end
endmodule

// ==== verification/period_timer_props.sv ====
// port assertions of the period timer
`timescale 1ns/1ps
module period_timer_chk #(
  parameter int POST_WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_ssp_match,
  input wire logic [7:0] o_pwm_count,
  input wire logic o_pwm_match,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic run;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) run <= 1'b0;
    else if (i_wr && i_addr == 4'h4) run <= i_wdata[2];
  end
  property p_bit7; $past(i_rd && i_addr == 4'h4) |-> !o_rdata[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("bit7 set");
  property p_pulse; o_pwm_match |=> !o_pwm_match; endproperty
  a_pulse: assert property (p_pulse) else $error("long match");
  property p_same; o_ssp_match == o_pwm_match; endproperty
  a_same: assert property (p_same) else $error("match split");
  property p_wrap; o_pwm_match |=> o_pwm_count == 8'h00; endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_step; !$past(i_wr) && !$past(i_wr, 2)
    && o_pwm_count != $past(o_pwm_count) |-> o_pwm_count == 8'h00
    || o_pwm_count == 8'($past(o_pwm_count) + 8'h01); endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_rise; $rose(o_irq) |-> $past(o_pwm_match) || $past(i_wr, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("stray irq");
  property p_fall; $fell(o_irq) |-> $past(i_wr, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq lost");
  property p_stop; !run && !$past(run) && !$past(i_wr) && !$past(i_wr, 2)
    |-> $stable(o_pwm_count); endproperty
  a_stop: assert property (p_stop) else $error("count moved");
endmodule
bind period_timer period_timer_chk #(.POST_WIDTH(POST_WIDTH)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ssp_match(o_ssp_match),
  .o_pwm_count(o_pwm_count), .o_pwm_match(o_pwm_match), .o_irq(o_irq));

// ==== verification/tb_top.sv ====
// self-checking testbench of the period timer
`timescale 1ns/1ps
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %0t value", $time); \
  end \
end
module tb_top;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata, o_pwm_count;
  logic o_ssp_match, o_pwm_match, o_irq;
  int mismatches = 0, comparisons = 0, cycles = 0, n, m, p;
  always #10 i_clk = ~i_clk;
  period_timer #(.POST_WIDTH(4)) DUT (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_ssp_match(o_ssp_match),
    .o_pwm_count(o_pwm_count), .o_pwm_match(o_pwm_match), .o_irq(o_irq));
  task end_sim;
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    `CHK(o_rdata, e)
    @(posedge i_clk);
  endtask
  // ----
  // clocks from one match pulse to the next
  // ----
  task gap(output int g);
    g = 0;
    do begin
      @(posedge i_clk);
      g++;
    end while (o_pwm_match !== 1'b1 && g < 5000);
  endtask
  initial begin
    void'($urandom(32'h6c9a));
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'hff);
    wr(4'h4, 8'hfb);
    rd(4'h4, 8'h7b);
    wr(4'h0, 8'h5a);
    wr(4'h8, 8'h3c);
    wr(4'h7, 8'hff);
    repeat (40) @(posedge i_clk);
    rd(4'h0, 8'h5a);
    rd(4'h8, 8'h3c);
    wr(4'h4, 8'h00);
    rd(4'h0, 8'h5a);
    for (int s = 0; s < 4; s++) begin
      p = $urandom % 8;
      wr(4'h8, 8'(p));
      wr(4'h0, 8'h00);
      wr(4'h4, 8'(4 + s));
      gap(n);
      gap(n);
      m = 4 * (s == 0 ? 1 : s == 1 ? 4 : 16) * (p + 1);
      `CHK(n, m)
    end
    wr(4'h8, 8'h00);
    wr(4'h1, 8'h02);
    for (int k = 0; k < 16; k++) begin
      wr(4'h4, 8'(k * 8));
      wr(4'hc, 8'h02);
      repeat (3) @(posedge i_clk);
      wr(4'h4, 8'(k * 8 + 4));
      m = 0;
      do begin
        @(posedge i_clk);
        if (o_pwm_match === 1'b1) m++;
      end while (o_irq !== 1'b1);
      `CHK(m, k + 1)
    end
    wr(4'h4, 8'h00);
    wr(4'h1, 8'h00);
    repeat (3) @(posedge i_clk);
    `CHK(o_irq, 1'b0)
    rd(4'hc, 8'h02);
    wr(4'h1, 8'h02);
    repeat (3) @(posedge i_clk);
    `CHK(o_irq, 1'b1)
    wr(4'hc, 8'h02);
    repeat (3) @(posedge i_clk);
    `CHK(o_irq, 1'b0)
    end_sim;
  end
endmodule
